// ### core/recovery_counter.v
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// stop recovery counter, held in clear until started
module recovery_counter (
  // clock and reset
  input  wire        i_clk,
  input  wire        i_rstn,
  // control
  input  wire        i_clear,
  input  wire        i_start,
  input  wire [12:0] i_limit,
  // status
  output reg         o_busy,
  output reg         o_done
);

  reg [12:0] count_r;

  // counts i_limit cycles after a start, then pulses done
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      count_r <= 13'h0000;
      o_busy  <= 1'b0;
      o_done  <= 1'b0;
    end else if (i_clear) begin
      count_r <= 13'h0000;
      o_busy  <= 1'b0;
      o_done  <= 1'b0;
    end else if (i_start && !o_busy) begin
      count_r <= 13'h0001;
      o_busy  <= 1'b1;
      o_done  <= 1'b0;
    end else if (o_busy) begin
      if (count_r >= i_limit) begin
        o_busy <= 1'b0;
        o_done <= 1'b1;
      end else begin
        count_r <= count_r + 13'h0001;
        o_done  <= 1'b0;
      end
    end else begin
      o_done <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ### core/sys_integ_map.vh
`ifndef SYS_INTEG_MAP_VH
`define SYS_INTEG_MAP_VH
// ==========================================================
// register indices (byte address is low 14 bits of index * 4)
`define IDX_BREAK_STATUS       16'hFE00
`define IDX_RESET_CAUSE        16'hFE01
`define IDX_BREAK_FLAG_CTRL    16'hFE03
`define IDX_IRQ_PEND_TWO       16'hFE04
`define IDX_IRQ_PEND_THREE     16'hFE05
`define IDX_IRQ_PEND_FOUR      16'hFE06
`define IDX_OPTION             16'hFE08
`define IDX_CPU_STATUS         16'hFE09
// ==========================================================
// field positions
`define BSR_EXIT_WAIT_BIT      1
`define RC_LVI_BIT             1
`define RC_MONITOR_ENTRY_RESET_CAUSE_BIT          2
`define RC_BADADDR_BIT         3
`define RC_BADOP_BIT           4
`define RC_WDOG_BIT            5
`define RC_PIN_BIT             6
`define RC_POR_BIT             7
`define BFC_CLEAR_EN_BIT       7
`define OPT_SHORT_REC_BIT      0
`define OPT_WDOG_DIS_BIT       1
// ==========================================================
// reset values
`define RC_RESET_VAL           8'h80
`define OPTION_RESET_VAL       8'h00
`define BFC_RESET_VAL          8'h00
// ==========================================================
// timing: counts in oscillator cycles
`define LONG_RECOVERY_CYC      4096
`define SHORT_RECOVERY_CYC     32
`define PIN_SAMPLE_CYC         32
`define INT_RESET_HOLD_CYC     32
`endif

// ### core/system_integration_unit.v
`timescale 1ns/100ps
`default_nettype none
`include "sys_integ_map.vh"
module system_integration_unit (
  // clock and reset
  input  wire        i_clk,
  input  wire        i_rstn,
  // avalon-mm slave
  input  wire [15:0] i_address,
  input  wire        i_read,
  input  wire        i_write,
  input  wire [31:0] i_writedata,
  output reg  [31:0] o_readdata,
  output reg         o_waitrequest,
  // cpu side
  input  wire        i_cpu_mask,
  input  wire        i_swi_instr,
  input  wire        i_wait_instr,
  input  wire        i_stop_instr,
  output reg         o_clear_cpu_mask,
  output reg         o_cpu_clk_en,
  output reg         o_periph_clk_en,
  output reg         o_osc_clk_en,
  output reg         o_stack_start,
  output reg  [4:0]  o_vector_num,
  output reg         o_vector_valid,
  // interrupt sources 1..24, bit n-1 is source n
  input  wire [23:0] i_irq_pending,
  // break and flag protection
  input  wire        i_break_req,
  output reg         o_break_state,
  output reg         o_flag_clear_allow,
  // reset causes (pulses from on-chip monitors)
  input  wire        i_por,
  input  wire        i_wdog_reset,
  input  wire        i_bad_opcode,
  input  wire        i_bad_addr,
  input  wire        i_monitor_entry,
  input  wire        i_low_voltage,
  // reset pin (open drain)
  input  wire        i_reset_pin,
  output reg         o_reset_pin_out,
  output reg         o_reset_pin_oe,
  output reg         o_internal_reset,
  // watchdog
  output reg         o_watchdog_run
);

  // ==========================================================
  // states
  localparam [1:0] ST_RUN  = 2'b00;
  localparam [1:0] ST_WAIT = 2'b01;
  localparam [1:0] ST_STOP = 2'b10;
  localparam [1:0] ST_REC  = 2'b11;

  localparam [1:0] PS_IDLE  = 2'b00;
  localparam [1:0] PS_HOLD  = 2'b01;
  localparam [1:0] PS_COUNT = 2'b10;

  // ==========================================================
  // state and registers
  reg  [1:0]  mode_r;
  reg  [1:0]  mode_nxt;
  reg  [1:0]  pin_st_r;
  reg  [5:0]  hold_cnt_r;
  reg  [7:0]  rc_r;
  reg  [7:0]  bfc_r;
  reg  [7:0]  option_r;
  reg         exit_wait_r;
  reg  [23:0] irq_s1_r;
  reg  [23:0] irq_s2_r;
  reg         brk_s1_r;
  reg         brk_s2_r;
  reg         pin_s1_r;
  reg         pin_s2_r;
  reg         stack_wait_r;
  reg         pend_rec_r;
  wire        rec_busy;
  wire        rec_done;
  wire [12:0] rec_limit;
  wire        any_irq;
  wire        int_reset_ev;
  wire        rd_clear;
  reg  [7:0]  rd_byte;

  // ==========================================================
  // helpers
  function [4:0] pick_source;
    input [23:0] req;
    integer k;
    begin
      pick_source = 5'h00;
      for (k = 23; k >= 0; k = k - 1) begin
        if (req[k])
          pick_source = k[4:0] + 5'h01;
      end
    end
  endfunction

  function hit;
    input [15:0] addr;
    input [15:0] idx;
    begin
      hit = (addr == {idx[13:0], 2'b00});
    end
  endfunction

  // ==========================================================
  // synchronisers for pins and asynchronous sources
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      irq_s1_r <= 24'h000000;
      irq_s2_r <= 24'h000000;
      brk_s1_r <= 1'b0;
      brk_s2_r <= 1'b0;
      pin_s1_r <= 1'b1;
      pin_s2_r <= 1'b1;
    end else begin
      irq_s1_r <= i_irq_pending;
      irq_s2_r <= irq_s1_r;
      brk_s1_r <= i_break_req;
      brk_s2_r <= brk_s1_r;
      pin_s1_r <= i_reset_pin;
      pin_s2_r <= pin_s1_r;
    end
  end

  // mask blocks maskable sources only; swi not part of this vector
  assign any_irq      = |irq_s2_r && !i_cpu_mask;
  assign int_reset_ev = i_wdog_reset | i_bad_opcode | i_bad_addr | i_monitor_entry | i_low_voltage;
  assign rec_limit    = option_r[`OPT_SHORT_REC_BIT] ? 13'd`SHORT_RECOVERY_CYC
                                                     : 13'd`LONG_RECOVERY_CYC;
  assign rd_clear     = i_read && !o_waitrequest && hit(i_address, `IDX_RESET_CAUSE);

  // ==========================================================
  // stop recovery counter
  recovery_counter u_rec (
    .i_clk   (i_clk),
    .i_rstn  (i_rstn),
    .i_clear (mode_r == ST_STOP && !any_irq),
    .i_start (mode_r == ST_REC),
    .i_limit (rec_limit),
    .o_busy  (rec_busy),
    .o_done  (rec_done)
  );

  // ==========================================================
  // low power sequencing
  always @* begin
    mode_nxt = mode_r;
    case (mode_r)
      ST_RUN: begin
        if (i_stop_instr)
          mode_nxt = ST_STOP;
        else if (i_wait_instr)
          mode_nxt = ST_WAIT;
      end
      ST_WAIT: begin
        if (any_irq || brk_s2_r)
          mode_nxt = ST_RUN;
      end
      ST_STOP: begin
        if (any_irq)
          mode_nxt = ST_REC;
      end
      ST_REC: begin
        if (rec_done)
          mode_nxt = ST_RUN;
      end
      default: mode_nxt = ST_RUN;
    endcase
  end

  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      mode_r           <= ST_RUN;
      o_clear_cpu_mask <= 1'b0;
      o_cpu_clk_en     <= 1'b1;
      o_periph_clk_en  <= 1'b1;
      o_osc_clk_en     <= 1'b1;
      o_stack_start    <= 1'b0;
      stack_wait_r     <= 1'b0;
      pend_rec_r       <= 1'b0;
      exit_wait_r      <= 1'b0;
      o_watchdog_run   <= 1'b0;
    end else if (int_reset_ev) begin // reset ends any low power mode
      mode_r           <= ST_RUN;
      o_clear_cpu_mask <= 1'b0;
      o_cpu_clk_en     <= 1'b1;
      o_periph_clk_en  <= 1'b1;
      o_osc_clk_en     <= 1'b1;
      o_stack_start    <= 1'b0;
      stack_wait_r     <= 1'b0;
      pend_rec_r       <= 1'b0;
      o_watchdog_run   <= !option_r[`OPT_WDOG_DIS_BIT];
    end else begin
      mode_r           <= mode_nxt;
      o_clear_cpu_mask <= (mode_r == ST_RUN) && (i_wait_instr || i_stop_instr);
      o_cpu_clk_en     <= (mode_nxt == ST_RUN);
      o_periph_clk_en  <= (mode_nxt != ST_STOP) && (mode_nxt != ST_REC);
      o_osc_clk_en     <= (mode_nxt != ST_STOP) && (mode_nxt != ST_REC);
      // wait wake-up: stacking two cycles after arrival
      stack_wait_r     <= (mode_r == ST_WAIT) && any_irq;
      pend_rec_r       <= (mode_r == ST_REC) && rec_done;
      o_stack_start    <= stack_wait_r || pend_rec_r;
      o_watchdog_run   <= !option_r[`OPT_WDOG_DIS_BIT];
      if (mode_r == ST_WAIT && brk_s2_r && !any_irq)
        exit_wait_r <= 1'b1;
      else if (i_write && !o_waitrequest && hit(i_address, `IDX_BREAK_STATUS)
               && !i_writedata[`BSR_EXIT_WAIT_BIT])
        exit_wait_r <= 1'b0;
    end
  end

  // ==========================================================
  // vector arbitration and break state
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_vector_num       <= 5'h00;
      o_vector_valid     <= 1'b0;
      o_break_state      <= 1'b0;
      o_flag_clear_allow <= 1'b1;
    end else begin
      if (brk_s2_r || i_swi_instr) begin
        o_vector_num   <= 5'h00; // software-interrupt vector
        o_vector_valid <= 1'b1;
      end else if (any_irq) begin
        o_vector_num   <= pick_source(irq_s2_r); // lowest number first
        o_vector_valid <= 1'b1;
      end else begin
        o_vector_num   <= 5'h00;
        o_vector_valid <= 1'b0;
      end
      if (brk_s2_r)
        o_break_state <= 1'b1;
      else if (!i_break_req && !brk_s1_r)
        o_break_state <= 1'b0;
      // peripherals gate the second step of their clear on this level
      o_flag_clear_allow <= !(brk_s2_r || o_break_state) || bfc_r[`BFC_CLEAR_EN_BIT];
    end
  end

  // ==========================================================
  // reset pin drive and sampling
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pin_st_r         <= PS_HOLD;
      hold_cnt_r       <= 6'h00;
      o_reset_pin_out  <= 1'b0;
      o_reset_pin_oe   <= 1'b1;
      o_internal_reset <= 1'b1;
    end else begin
      case (pin_st_r)
        PS_IDLE: begin
          if (int_reset_ev) begin
            pin_st_r         <= PS_HOLD;
            hold_cnt_r       <= 6'h00;
            o_reset_pin_oe   <= 1'b1;
            o_internal_reset <= 1'b1;
          end
        end
        PS_HOLD: begin
          if (hold_cnt_r == 6'd`INT_RESET_HOLD_CYC - 6'h01) begin
            pin_st_r       <= PS_COUNT;
            hold_cnt_r     <= 6'h00;
            o_reset_pin_oe <= 1'b0;
          end else begin
            hold_cnt_r <= hold_cnt_r + 6'h01;
          end
        end
        PS_COUNT: begin
          if (hold_cnt_r == 6'd`PIN_SAMPLE_CYC - 6'h01) begin
            pin_st_r         <= PS_IDLE;
            o_internal_reset <= 1'b0;
          end else begin
            hold_cnt_r <= hold_cnt_r + 6'h01;
          end
        end
        default: pin_st_r <= PS_IDLE;
      endcase
      o_reset_pin_out <= 1'b0;
    end
  end

  // ==========================================================
  // reset cause flags: set wins over read-clear
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rc_r <= `RC_RESET_VAL; // power-on sets only its own flag
    end else begin
      if (i_por)
        rc_r <= `RC_RESET_VAL;
      else begin
        rc_r[`RC_POR_BIT]     <= rc_r[`RC_POR_BIT] && !rd_clear;
        rc_r[`RC_WDOG_BIT]    <= i_wdog_reset    || (rc_r[`RC_WDOG_BIT] && !rd_clear);
        rc_r[`RC_BADOP_BIT]   <= i_bad_opcode    || (rc_r[`RC_BADOP_BIT] && !rd_clear);
        rc_r[`RC_BADADDR_BIT] <= i_bad_addr      || (rc_r[`RC_BADADDR_BIT] && !rd_clear);
        rc_r[`RC_MONITOR_ENTRY_RESET_CAUSE_BIT]  <= i_monitor_entry || (rc_r[`RC_MONITOR_ENTRY_RESET_CAUSE_BIT] && !rd_clear);
        rc_r[`RC_LVI_BIT]     <= i_low_voltage   || (rc_r[`RC_LVI_BIT] && !rd_clear);
        rc_r[`RC_PIN_BIT]     <= (pin_st_r == PS_COUNT
                                  && hold_cnt_r == 6'd`PIN_SAMPLE_CYC - 6'h01 && !pin_s2_r)
                                 || (rc_r[`RC_PIN_BIT] && !rd_clear);
        rc_r[0]               <= 1'b0;
      end
    end
  end

  // ==========================================================
  // writable registers; pending registers ignore writes
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      bfc_r    <= `BFC_RESET_VAL;
      option_r <= `OPTION_RESET_VAL;
    end else if (i_write && !o_waitrequest) begin
      if (hit(i_address, `IDX_BREAK_FLAG_CTRL))
        bfc_r <= i_writedata[7:0] & 8'h80;
      if (hit(i_address, `IDX_OPTION))
        option_r <= i_writedata[7:0] & 8'h03;
    end
  end

  // ==========================================================
  // read mux
  always @* begin
    rd_byte = 8'h00;
    if (hit(i_address, `IDX_BREAK_STATUS))
      rd_byte = {6'h00, exit_wait_r, 1'b0};
    else if (hit(i_address, `IDX_RESET_CAUSE))
      rd_byte = rc_r;
    else if (hit(i_address, `IDX_BREAK_FLAG_CTRL))
      rd_byte = bfc_r;
    else if (hit(i_address, `IDX_IRQ_PEND_TWO))
      rd_byte = irq_s2_r[13:6];
    else if (hit(i_address, `IDX_IRQ_PEND_THREE))
      rd_byte = irq_s2_r[21:14];
    else if (hit(i_address, `IDX_IRQ_PEND_FOUR))
      rd_byte = {6'h00, irq_s2_r[23:22]};
    else if (hit(i_address, `IDX_OPTION))
      rd_byte = option_r;
    else if (hit(i_address, `IDX_CPU_STATUS))
      rd_byte = {5'h00, o_break_state, mode_r};
  end

  // ==========================================================
  // avalon slave: one wait cycle, answer on second edge
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_waitrequest <= 1'b1;
      o_readdata    <= 32'h00000000;
    end else begin
      if ((i_read || i_write) && o_waitrequest) begin
        o_waitrequest <= 1'b0;
        o_readdata    <= {24'h000000, rd_byte};
      end else begin
        o_waitrequest <= 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// ### verif/periph_model.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// peripheral with a two-step cleared flag, plus the reset line
module periph_model (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rstn,
  // reset line
  input  wire logic i_pin_oe,
  input  wire logic i_ext_low,
  output wire logic o_pin,
  // status flag
  input  wire logic i_flag_set,
  input  wire logic i_step_one,
  input  wire logic i_step_two,
  input  wire logic i_clear_allow,
  output var  logic o_flag
);
  logic armed_r;
  // pulled-up line, low when anyone pulls it
  assign o_pin = !(i_pin_oe || i_ext_low);
  // second step clears only while clearing is allowed
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_flag <= 1'b0;
      armed_r <= 1'b0;
    end else begin
      if (i_step_one)
        armed_r <= 1'b1;
      if (i_flag_set)
        o_flag <= 1'b1;
      else if (i_step_two && armed_r && i_clear_allow) begin
        o_flag <= 1'b0;
        armed_r <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ### verif/sys_integ_checker.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// port checks of the integration unit
module sys_integ_checker (
  // clock and reset
  input wire logic        i_clk,
  input wire logic        i_rstn,
  // register bus
  input wire logic [15:0] i_address,
  input wire logic        i_read,
  input wire logic        i_write,
  input wire logic [31:0] o_readdata,
  input wire logic        o_waitrequest,
  // cpu and clocks
  input wire logic        i_wait_instr,
  input wire logic        i_stop_instr,
  input wire logic        o_clear_cpu_mask,
  input wire logic        o_cpu_clk_en,
  input wire logic        o_periph_clk_en,
  input wire logic        o_osc_clk_en,
  input wire logic [4:0]  o_vector_num,
  input wire logic        o_vector_valid,
  input wire logic        o_break_state,
  // reset pin
  input wire logic        o_reset_pin_oe,
  input wire logic        o_internal_reset
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  // ==========================================================
  // building blocks
  sequence taken_s; (i_read || i_write) && o_waitrequest; endsequence
  sequence answer_s; !o_waitrequest ##1 o_waitrequest; endsequence
  sequence run_s; o_cpu_clk_en && o_osc_clk_en && !o_internal_reset && !o_break_state; endsequence
  // ==========================================================
  // properties
  bus_answer_a: assert property (taken_s |=> answer_s)
    else $error("bus answer out of step");
  upper_zero_a: assert property (i_read && !o_waitrequest |-> o_readdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  pend_four_a: assert property (i_read && !o_waitrequest && i_address == 16'hF818 |-> o_readdata[7:2] == 6'h0)
    else $error("pending four high bits set");
  mask_clear_a: assert property (((i_wait_instr || i_stop_instr) and run_s) |=> o_clear_cpu_mask)
    else $error("mask not cleared");
  wait_gate_a: assert property ((i_wait_instr and run_s) |-> ##[1:3] (!o_cpu_clk_en && o_periph_clk_en))
    else $error("wait clock gating wrong");
  stop_gate_a: assert property ((i_stop_instr and run_s) |-> ##[1:3] !(o_cpu_clk_en || o_periph_clk_en || o_osc_clk_en))
    else $error("stop clock gating wrong");
  pin_hold_a: assert property ($fell(o_reset_pin_oe) |-> o_internal_reset [*8])
    else $error("reset ended before pin sample");
  break_vec_a: assert property ($rose(o_break_state) |-> ##[0:2] (o_vector_valid && o_vector_num == 5'h00))
    else $error("break did not force swi vector");
endmodule
bind system_integration_unit sys_integ_checker chk (.i_clk(i_clk), .i_rstn(i_rstn), .i_address(i_address),
  .i_read(i_read), .i_write(i_write), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
  .i_wait_instr(i_wait_instr), .i_stop_instr(i_stop_instr), .o_clear_cpu_mask(o_clear_cpu_mask),
  .o_cpu_clk_en(o_cpu_clk_en), .o_periph_clk_en(o_periph_clk_en), .o_osc_clk_en(o_osc_clk_en),
  .o_vector_num(o_vector_num), .o_vector_valid(o_vector_valid), .o_break_state(o_break_state),
  .o_reset_pin_oe(o_reset_pin_oe), .o_internal_reset(o_internal_reset));
`default_nettype wire

// ### verif/tb_system_integration_unit.sv
`timescale 1ns/100ps
`default_nettype none
module tb_system_integration_unit;
  logic        clk, rstn, rd, wr, mask, software_interrupt_instr, wt, stp, brk;
  logic [15:0] adr;
  logic [31:0] wd;
  logic [23:0] irq;
  logic [7:0]  cause, q;
  logic [2:0]  pc;
  wire  [31:0] rdata;
  wire  [4:0]  vnum;
  wire         wreq, clrm, cpuen, peren, oscen, stk, vval, bst, allow, pin, poe, irst, wdr, flag;
  int          n_errors, compares, n, pend, lim;
  int          cl[$] = '{1, 2, 3, 4, 5, 6, 5, 7};
  // ==========================================================
  // design and far side
  system_integration_unit dut (.i_clk(clk), .i_rstn(rstn), .i_address(adr), .i_read(rd), .i_write(wr),
    .i_writedata(wd), .o_readdata(rdata), .o_waitrequest(wreq), .i_cpu_mask(mask), .i_swi_instr(software_interrupt_instr),
    .i_wait_instr(wt), .i_stop_instr(stp), .o_clear_cpu_mask(clrm), .o_cpu_clk_en(cpuen),
    .o_periph_clk_en(peren), .o_osc_clk_en(oscen), .o_stack_start(stk), .o_vector_num(vnum),
    .o_vector_valid(vval), .i_irq_pending(irq), .i_break_req(brk), .o_break_state(bst),
    .o_flag_clear_allow(allow), .i_por(cause[7]), .i_wdog_reset(cause[5]), .i_bad_opcode(cause[4]),
    .i_bad_addr(cause[3]), .i_monitor_entry(cause[2]), .i_low_voltage(cause[1]), .i_reset_pin(pin),
    .o_reset_pin_out(), .o_reset_pin_oe(poe), .o_internal_reset(irst), .o_watchdog_run(wdr));
  periph_model pm (.i_clk(clk), .i_rstn(rstn), .i_pin_oe(poe), .i_ext_low(cause[6]), .o_pin(pin),
    .i_flag_set(pc[2]), .i_step_one(pc[0]), .i_step_two(pc[1]), .i_clear_allow(allow), .o_flag(flag));
  // ==========================================================
  // helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %0t seen %0h exp %0h", $time, seen, exp);
    end
  endtask
  // one bus transfer, entered just after a rising edge
  task automatic bus(input logic [15:0] a, input logic w, input logic [7:0] d);
    int k;
    k = 0;
    adr <= a;
    rd <= !w;
    wr <= w;
    wd <= {24'h0, d};
    @(posedge clk);
    while (wreq !== 1'b0 && k < 50) begin
      @(posedge clk);
      k++;
    end
    if (k == 50)
      n_errors++;
    // completion edge: take the data, then release
    q = rdata[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask
  // one-cycle pulse on the peripheral controls
  task automatic pp(input logic [2:0] v);
    pc <= v;
    @(posedge clk);
    pc <= 3'h0;
    @(posedge clk);
  endtask
  // cycles until stacking begins
  task automatic to_stack(input int lim_c);
    @(negedge clk);
    for (n = 1; n < lim_c && stk !== 1'b1; n++)
      @(negedge clk);
    @(posedge clk);
  endtask
  function automatic logic [4:0] lowest(input int p);
    lowest = 5'h00;
    for (int b = 23; b >= 0; b--)
      if (p[b])
        lowest = 5'(b + 1);
  endfunction
  task automatic final_report;
    if (n_errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ==========================================================
  // clock, cpu mask model and watchdog
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    if (clrm === 1'b1)
      mask <= 1'b0;
  end
  initial begin
    #200000;
    n_errors++;
    final_report();
  end
  // ==========================================================
  // main sequence
  initial begin
    {rstn, rd, wr, software_interrupt_instr, wt, stp, brk, pc, cause, irq, adr, wd} = '0;
    mask = 1'b1;
    void'($urandom(32'h17d3));
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    for (n = 0; n < 300 && irst !== 1'b0; n++) @(posedge clk);
    bus(16'hF804, 0, 0); check(q, 8'h80);
    bus(16'hF804, 0, 0); check(q, 8'h00);
    bus(16'hF80C, 0, 0); check(q, 8'h00);
    bus(16'hF83C, 1, 8'hAA);
    bus(16'hF83C, 0, 0); check(q, 8'h00);
    // pending flags, vector choice and masking
    for (int i = 0; i < 4; i++) begin
      pend = (i == 0) ? 'h800000 : (i == 1) ? 'h40 : $urandom % 'hFFFFFF + 1;
      irq <= pend[23:0];
      mask <= 1'b0;
      repeat (4) @(posedge clk);
      bus(16'hF810, 0, 0); check(q, (pend >> 6) & 'hFF);
      bus(16'hF814, 0, 0); check(q, (pend >> 14) & 'hFF);
      bus(16'hF818, 0, 0); check(q, pend >> 22);
      bus(16'hF810, 1, 8'hFF);
      bus(16'hF810, 0, 0); check(q, (pend >> 6) & 'hFF);
      @(negedge clk); check({vval, vnum}, {1'b1, lowest(pend)});
      @(posedge clk);
    end
    mask <= 1'b1;
    repeat (3) @(negedge clk); check(vval, 1'b0);
    @(posedge clk);
    software_interrupt_instr <= 1'b1;
    @(posedge clk);
    software_interrupt_instr <= 1'b0;
    for (n = 0; n < 8 && vval !== 1'b1; n++) @(negedge clk);
    check({vval, vnum}, 6'h20);
    @(posedge clk);
    irq <= 24'h0;
    bus(16'hF820, 1, 8'h02);
    bus(16'hF820, 0, 0); check({q, wdr}, 9'h004);
    bus(16'hF820, 1, 8'h00);
    // wait, then break while waiting, with flag protection
    pp(3'b101);
    wt <= 1'b1;
    @(posedge clk);
    wt <= 1'b0;
    @(negedge clk); check(clrm, 1'b1);
    repeat (3) @(negedge clk); check({cpuen, peren, wdr}, 3'b011);
    @(posedge clk);
    brk <= 1'b1;
    for (n = 0; n < 8 && bst !== 1'b1; n++) @(posedge clk);
    bus(16'hF800, 0, 0); check(q, 8'h02);
    pp(3'b010); check({flag, allow}, 2'b10);
    bus(16'hF80C, 1, 8'h80); @(negedge clk); check(allow, 1'b1);
    @(posedge clk);
    bus(16'hF80C, 1, 8'h00); @(negedge clk); check(allow, 1'b0);
    @(posedge clk);
    brk <= 1'b0;
    for (n = 0; n < 8 && bst !== 1'b0; n++) @(posedge clk);
    repeat (2) @(posedge clk);
    pp(3'b010); check(flag, 1'b0);
    bus(16'hF800, 1, 8'h00);
    bus(16'hF800, 0, 0); check(q, 8'h00);
    // interrupt wakes from wait
    wt <= 1'b1;
    @(posedge clk);
    wt <= 1'b0;
    repeat (3) @(posedge clk);
    irq <= 24'h000200;
    to_stack(20); check({n >= 3 && n <= 6, cpuen}, 2'b11);
    irq <= 24'h0;
    // stop, short recovery first, then the long one kept for crystals
    for (int s = 0; s < 2; s++) begin
      lim = (s == 0) ? 32 : 4096;
      bus(16'hF820, 1, {7'h0, s == 0});
      stp <= 1'b1;
      @(posedge clk);
      stp <= 1'b0;
      repeat (4) @(negedge clk); check({oscen, peren, cpuen}, 3'b000);
      @(posedge clk);
      irq <= 24'h000001;
      to_stack(5000); check(n >= lim && n <= lim + 8, 1'b1);
      irq <= 24'h0;
    end
    // reset causes, power-on last over a pending watchdog flag
    foreach (cl[i]) begin
      // pin case: a watchdog reset while the line is held low from outside
      cause <= (8'h01 << cl[i]) | ((cl[i] == 6) ? 8'h20 : 8'h00);
      @(posedge clk);
      cause <= (cl[i] == 6) ? 8'h40 : 8'h00;
      for (n = 0; n < 20 && irst !== 1'b1; n++) @(posedge clk);
      for (n = 0; n < 300 && irst !== 1'b0; n++) @(posedge clk);
      cause <= 8'h00;
      @(posedge clk);
      if (i != 6) begin
        bus(16'hF804, 0, 0); check(q, cl[i] == 7 ? 'h80 : cl[i] == 6 ? 'h60 : 1 << cl[i]);
      end
    end
    final_report();
  end
endmodule
`default_nettype wire
